// file: lcf_link_connection_fsm.v
// Function
// R1: Keep clock-compensation insertion in every state
// R2: Active after phy reset, idle after identification
// R3: Ignore errors and unhandled primitives
// R4: Internal link error goes to abort-wait
// R5: Leave idle only on request or OPEN; the code also leaves idle on link error
// R6: Transmit idle dwords while idle
// R7: Open request to arbitrate, parameters latched
// R8: Valid OPEN in idle goes to selected
// R9: Send OPEN frame with latched fields
// R10: Start one millisecond timer after OPEN sent
// R11: Each AIP reloads timer, unlimited
// R12: Fairness uses latched arbitration wait time
// R13: Losing OPEN without AIP is ignored
// R14: Any reject returns to idle
// R15: Wrong destination reports wait time, reason
// R16: Other rejects report matching reason
// R17: With AIP, valid OPEN wins to selected
// R18: Without AIP, winning OPEN goes selected
// R19: Accept confirms protocol then goes open
// R20: Hash for SSP and SMP only
// R21: Stop request confirms lost, abort-wait
// R22: Timeout confirms lost, abort-wait
// R23: Break received confirms lost, abort state
// R24: Timer sized from clock frequency parameter
`timescale 1ns/1ps
`default_nettype none
`include "lcf_map.vh"
module lcf_link_connection_fsm #(
  // Field widths
  parameter ID_W = 64,
  parameter AWT_W = 16,
  parameter RATE_W = 4,
  parameter HASH_W = 24,
  // Open time-out derived from the clock rate
  parameter CLK_HZ = `LCF_CLK_HZ,
  parameter OPEN_TMO_US = `LCF_OPEN_TMO_US,
  parameter TMO_CYC = (CLK_HZ / 1000000) * OPEN_TMO_US
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Phy status, same clock
  input wire phyResetDone,
  input wire identDone,
  input wire [ID_W-1:0] localId,
  // Port layer requests
  input wire openReq,
  input wire [ID_W-1:0] reqDestId,
  input wire [2:0] reqProto,
  input wire [AWT_W-1:0] reqAwt,
  input wire [RATE_W-1:0] reqRate,
  input wire stopArbReq,
  input wire [2:0] supportedProtos,
  // Received link events, one-cycle pulses
  input wire rxOpenFrame,
  input wire rxOpenCrcErr,
  input wire [ID_W-1:0] rxDestId,
  input wire [ID_W-1:0] rxSrcId,
  input wire [2:0] rxProto,
  input wire [AWT_W-1:0] rxAwt,
  input wire [RATE_W-1:0] rxRate,
  input wire rxAip,
  input wire rxOpenAccept,
  input wire rxOpenReject,
  input wire [2:0] rxRejectCode,
  input wire rxBreak,
  input wire linkErr,
  // Exit from states handled elsewhere
  input wire stateExit,
  // Transmit side
  output reg txIdle,
  output reg txOpenFrame,
  output reg [ID_W-1:0] txDestId,
  output reg [2:0] txProto,
  output reg [AWT_W-1:0] txAwt,
  output reg [RATE_W-1:0] txRate,
  input wire txOpenDone,
  output wire txAlignAllowed,
  // Port layer confirmations
  output reg cnfValid,
  output reg [3:0] cnfReason,
  output reg [AWT_W-1:0] cnfAwt,
  output reg cnfOpened,
  output reg [2:0] cnfProto,
  // Parameters to next states
  output reg selValid,
  output reg [ID_W-1:0] selDestId,
  output reg [2:0] selProto,
  output reg [RATE_W-1:0] selRate,
  output reg [HASH_W-1:0] connHash,
  output reg connHashValid,
  output wire [`LCF_ST_W-1:0] state
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Counter just wide enough for one time-out period
  localparam CNT_W = (TMO_CYC > 2) ? $clog2(TMO_CYC) : 1; // R24
  // Reload value, one less since zero counts as a cycle
  localparam TMO_M1 = TMO_CYC - 1;
  localparam [CNT_W-1:0] TMO_RELOAD = TMO_M1[CNT_W-1:0]; // R10
  reg [`LCF_ST_W-1:0] state_q; // Current state
  reg [`LCF_ST_W-1:0] state_d; // Next state
  reg [CNT_W-1:0] tmo_q; // Open time-out counter
  reg tmoRun_q; // Timer running
  reg aipSeen_q; // AIP seen in this arbitration
  reg frameSent_q; // OPEN frame went out
  reg [ID_W-1:0] srcDestId_q; // Peer for the hash: own request destination, or source of the selecting OPEN
  wire rxValidOpen; // Valid received OPEN
  wire rxWins; // Received OPEN wins fairness
  wire tmoExpired; // Timer ran out
  wire [HASH_W-1:0] hashVal; // Source/destination hash
  // ----------------------------------------
  // Frame checks and timer status
  // ----------------------------------------
  // Valid OPEN: no CRC error, supported protocol, our identifier
  assign rxValidOpen = rxOpenFrame && !rxOpenCrcErr &&
    ((rxProto & supportedProtos) != 3'h0) && (rxDestId == localId); // R8
  // Fairness: larger wait time wins, tie broken by larger source id
  assign rxWins = (rxAwt > txAwt) ||
    ((rxAwt == txAwt) && (rxSrcId > localId)); // R12
  // Timer hits zero while armed
  assign tmoExpired = tmoRun_q && (tmo_q == {CNT_W{1'b0}});
  // Fold both identifiers into a short hash
  assign hashVal = localId[HASH_W-1:0] ^ srcDestId_q[HASH_W-1:0];
  // Clock compensation never blocked by connection state
  assign txAlignAllowed = 1'b1; // R1
  // State seen by the checker and the next stages
  assign state = state_q;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    // Hold unless a handled event arrives
    state_d = state_q; // R3
    case (state_q)
      `LCF_ST_RESET: begin
        // Wait for phy reset and identification
        if (phyResetDone && identDone)
          state_d = `LCF_ST_IDLE; // R2
      end
      `LCF_ST_IDLE: begin
        // Other inputs ignored here
        if (linkErr)
          state_d = `LCF_ST_ABORTW; // R4
        else if (rxValidOpen)
          state_d = `LCF_ST_SEL; // R8
        else if (openReq)
          state_d = `LCF_ST_ARB; // R5 R7
      end
      `LCF_ST_ARB: begin
        // Exits in fixed priority order
        if (linkErr)
          state_d = `LCF_ST_ABORTW; // R4
        else if (rxBreak)
          state_d = `LCF_ST_ABORT; // R23
        else if (rxOpenReject)
          state_d = `LCF_ST_IDLE; // R14
        else if (rxOpenAccept)
          state_d = `LCF_ST_OPEN; // R19
        else if (rxValidOpen && (aipSeen_q || rxWins))
          state_d = `LCF_ST_SEL; // R17 R18
        else if (stopArbReq)
          state_d = `LCF_ST_ABORTW; // R21
        else if (tmoExpired)
          state_d = `LCF_ST_ABORTW; // R22
        // Losing OPEN without AIP falls through R13
      end
      `LCF_ST_SEL, `LCF_ST_OPEN, `LCF_ST_CLOSEW, `LCF_ST_ABORTW, `LCF_ST_ABORT: begin
        // Internals of these states live elsewhere
        if (linkErr && state_q != `LCF_ST_ABORTW)
          state_d = `LCF_ST_ABORTW; // R4
        else if (stateExit)
          state_d = `LCF_ST_IDLE;
      end
      // Illegal code falls back to reset
      default: state_d = `LCF_ST_RESET;
    endcase
  end
  // ----------------------------------------
  // State, timer and latched request
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= `LCF_ST_RESET;
      tmo_q <= {CNT_W{1'b0}};
      tmoRun_q <= 1'b0;
      aipSeen_q <= 1'b0;
      frameSent_q <= 1'b0;
      srcDestId_q <= {ID_W{1'b0}};
      txDestId <= {ID_W{1'b0}};
      txProto <= 3'h0;
      txAwt <= {AWT_W{1'b0}};
      txRate <= {RATE_W{1'b0}};
    end else begin
      // Advance the machine
      state_q <= state_d;
      // Capture request on idle to arbitrate
      if (state_q == `LCF_ST_IDLE && state_d == `LCF_ST_ARB) begin
        // Request fields held for the OPEN frame
        txDestId <= reqDestId; // R7
        txProto <= reqProto; // R7
        txAwt <= reqAwt; // R7
        txRate <= reqRate; // R7
        aipSeen_q <= 1'b0;
        frameSent_q <= 1'b0;
        tmoRun_q <= 1'b0;
      end else if (state_q == `LCF_ST_ARB) begin
        // Any AIP marks the peer as busy, even beside frame end
        if (rxAip)
          aipSeen_q <= 1'b1; // R13 R17
        // Timer loaded once, when the frame has gone out
        if (txOpenDone && !frameSent_q) begin
          frameSent_q <= 1'b1;
          tmo_q <= TMO_RELOAD; // R10 R24
          tmoRun_q <= 1'b1; // R10
        end else if (rxAip) begin
          // AIP restarts the full period, no limit on count
          tmo_q <= TMO_RELOAD; // R11
        end else if (tmoRun_q && tmo_q != {CNT_W{1'b0}}) begin
          // Count down while armed
          tmo_q <= tmo_q - 1'b1;
        end
      end else begin
        // Flags cleared outside arbitrate, ready for the next request
        tmoRun_q <= 1'b0;
        aipSeen_q <= 1'b0;
        frameSent_q <= 1'b0;
      end
      // Remember peer for the hash, never a losing frame
      if (rxValidOpen && state_d == `LCF_ST_SEL)
        srcDestId_q <= rxSrcId;
      // Own request's destination when arbitration starts
      else if (state_q == `LCF_ST_IDLE && state_d == `LCF_ST_ARB)
        srcDestId_q <= reqDestId;
    end
  end
  // ----------------------------------------
  // Outputs registered with the transition
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txIdle <= 1'b0;
      txOpenFrame <= 1'b0;
      cnfValid <= 1'b0;
      cnfReason <= 4'h0;
      cnfAwt <= {AWT_W{1'b0}};
      cnfOpened <= 1'b0;
      cnfProto <= 3'h0;
      selValid <= 1'b0;
      selDestId <= {ID_W{1'b0}};
      selProto <= 3'h0;
      selRate <= {RATE_W{1'b0}};
      connHash <= {HASH_W{1'b0}};
      connHashValid <= 1'b0;
    end else begin
      txIdle <= (state_d == `LCF_ST_IDLE); // R6
      txOpenFrame <= (state_d == `LCF_ST_ARB) && !frameSent_q && !txOpenDone; // R9
      // One-cycle pulses default low
      cnfValid <= 1'b0;
      cnfOpened <= 1'b0;
      selValid <= 1'b0;
      if (state_q == `LCF_ST_ARB) begin
        if (state_d == `LCF_ST_IDLE) begin
          // Rejection: wait time and matching reason
          cnfValid <= 1'b1;
          cnfAwt <= txAwt; // R15
          case (rxRejectCode)
            `LCF_REJ_WRONG_DEST: cnfReason <= `LCF_RSN_FAIL_WRONG_DEST; // R15
            `LCF_REJ_BAD_RATE: cnfReason <= `LCF_RSN_FAIL_BAD_RATE; // R16
            `LCF_REJ_BAD_PROTO: cnfReason <= `LCF_RSN_FAIL_BAD_PROTO; // R16
            `LCF_REJ_RETRY: cnfReason <= `LCF_RSN_FAIL_RETRY; // R16
            `LCF_REJ_BLOCKED: cnfReason <= `LCF_RSN_FAIL_BLOCKED; // R16
            default: cnfReason <= `LCF_RSN_FAIL_OTHER;
          endcase
        end else if (state_d == `LCF_ST_ABORT) begin
          // Break received while arbitrating
          cnfValid <= 1'b1;
          cnfReason <= `LCF_RSN_LOST_BREAK; // R23
        end else if (state_d == `LCF_ST_ABORTW && !linkErr) begin
          // Stop request outranks time-out, link error stays silent
          cnfValid <= 1'b1;
          cnfReason <= stopArbReq ? `LCF_RSN_LOST_PORT_REQ : `LCF_RSN_LOST_TIMEOUT; // R21 R22
        end else if (state_d == `LCF_ST_OPEN) begin
          // Accept: report the transmitted protocol
          cnfOpened <= 1'b1; // R19
          cnfProto <= txProto; // R19
          connHash <= hashVal;
          connHashValid <= (txProto != `LCF_PROTO_STP); // R20
        end
      end
      // Selected entry carries the requester's fields
      if (state_d == `LCF_ST_SEL && state_q != `LCF_ST_SEL) begin
        selValid <= 1'b1; // R8 R17 R18
        selDestId <= rxDestId;
        selProto <= rxProto;
        selRate <= rxRate;
      end
    end
  end
endmodule
`default_nettype wire

// file: lcf_map.vh
`ifndef LCF_MAP_VH
`define LCF_MAP_VH
// ----------------------------------------
// State codes, one-hot
// ----------------------------------------
`define LCF_ST_W 8
`define LCF_ST_RESET 8'h01
`define LCF_ST_IDLE 8'h02
`define LCF_ST_ARB 8'h04
`define LCF_ST_SEL 8'h08
`define LCF_ST_OPEN 8'h10
`define LCF_ST_CLOSEW 8'h20
`define LCF_ST_ABORTW 8'h40
`define LCF_ST_ABORT 8'h80
// ----------------------------------------
// Protocol codes
// ----------------------------------------
`define LCF_PROTO_SSP 3'h1
`define LCF_PROTO_SMP 3'h2
`define LCF_PROTO_STP 3'h4
// ----------------------------------------
// Reject codes received
// ----------------------------------------
`define LCF_REJ_WRONG_DEST 3'h0
`define LCF_REJ_BAD_RATE 3'h1
`define LCF_REJ_BAD_PROTO 3'h2
`define LCF_REJ_RETRY 3'h3
`define LCF_REJ_BLOCKED 3'h4
// ----------------------------------------
// Reason codes to the port layer
// ----------------------------------------
`define LCF_RSN_FAIL_WRONG_DEST 4'h1
`define LCF_RSN_FAIL_BAD_RATE 4'h2
`define LCF_RSN_FAIL_BAD_PROTO 4'h3
`define LCF_RSN_FAIL_RETRY 4'h4
`define LCF_RSN_FAIL_BLOCKED 4'h5
`define LCF_RSN_FAIL_OTHER 4'h6
`define LCF_RSN_LOST_PORT_REQ 4'h8
`define LCF_RSN_LOST_TIMEOUT 4'h9
`define LCF_RSN_LOST_BREAK 4'ha
// ----------------------------------------
// Timing
// ----------------------------------------
`define LCF_CLK_HZ 20000000
`define LCF_OPEN_TMO_US 1000
`endif

// file: lcf_conn_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcf_map.vh"
module lcf_conn_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Stimulus seen
  input wire logic phyResetDone,
  input wire logic identDone,
  input wire logic openReq,
  input wire logic rxOpenFrame,
  input wire logic rxOpenReject,
  input wire logic [2:0] rxRejectCode,
  input wire logic rxOpenAccept,
  input wire logic rxBreak,
  input wire logic linkErr,
  input wire logic stopArbReq,
  // Answers seen
  input wire logic txIdle,
  input wire logic cnfValid,
  input wire logic [3:0] cnfReason,
  input wire logic cnfOpened,
  input wire logic [7:0] state
);
  // ----------------------------------------
  // State shorthands
  // ----------------------------------------
  wire inRst = state == `LCF_ST_RESET;
  wire inIdle = state == `LCF_ST_IDLE;
  wire inArb = state == `LCF_ST_ARB;
  wire calm = !linkErr && !rxBreak;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_hold; inRst && !(phyResetDone && identDone) |=> inRst; endproperty
  a_hold: assert property (p_hold) else $error("left reset early");
  property p_txidle; inIdle |-> txIdle; endproperty
  a_txidle: assert property (p_txidle) else $error("no idle dwords");
  property p_req; inIdle && openReq && !rxOpenFrame && !linkErr |=> inArb; endproperty
  a_req: assert property (p_req) else $error("request not taken");
  property p_err; (inIdle || inArb) && linkErr |=> state == `LCF_ST_ABORTW; endproperty
  a_err: assert property (p_err) else $error("link error ignored");
  property p_rej; inArb && rxOpenReject && calm && rxRejectCode < 3'h5
    |=> inIdle && cnfValid && cnfReason == {1'b0, $past(rxRejectCode)} + 4'h1; endproperty
  a_rej: assert property (p_rej) else $error("bad reject handling");
  property p_acc; inArb && rxOpenAccept && calm && !rxOpenReject
    |=> cnfOpened && state == `LCF_ST_OPEN; endproperty
  a_acc: assert property (p_acc) else $error("bad accept handling");
  property p_stop; inArb && stopArbReq && calm && !(rxOpenReject || rxOpenAccept || rxOpenFrame)
    |=> cnfValid && cnfReason == 4'h8 && state == `LCF_ST_ABORTW; endproperty
  a_stop: assert property (p_stop) else $error("bad stop handling");
  property p_brk; inArb && rxBreak && !linkErr
    |=> cnfValid && cnfReason == 4'ha && state == `LCF_ST_ABORT; endproperty
  a_brk: assert property (p_brk) else $error("bad break handling");
  c_acc: cover property (cnfOpened);
  c_tmo: cover property (cnfValid && cnfReason == 4'h9);
  c_rej: cover property (cnfValid && cnfReason == 4'h1);
endmodule
bind lcf_link_connection_fsm lcf_conn_sva u_sva (.*);
`default_nettype wire

// file: lcf_remote_port.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_remote_port (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Answer kind: 0 accept, 1 reject, 2 silent, 3 arbitration in progress
  input wire logic [1:0] mode,
  // Link side
  input wire logic txOpenFrame,
  output logic txOpenDone,
  output logic rxAip,
  output logic rxOpenAccept,
  output logic rxOpenReject
);
  logic [3:0] cnt_q; // Cycles since the frame started
  // Frame ends after four cycles, answer comes five later
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      {txOpenDone, rxAip, rxOpenAccept, rxOpenReject} <= 4'h0;
    end else begin
      cnt_q <= (cnt_q != 4'h0 || txOpenFrame) ? cnt_q + 4'h1 : 4'h0;
      txOpenDone <= cnt_q == 4'h3;
      rxOpenAccept <= cnt_q == 4'h8 && mode == 2'd0;
      rxOpenReject <= cnt_q == 4'h8 && mode == 2'd1;
      rxAip <= cnt_q == 4'h8 && mode == 2'd3;
    end
  end
endmodule
`default_nettype wire

// file: lcf_link_connection_fsm_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcf_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t mismatch", $time); end end
module lcf_link_connection_fsm_test;
  logic clk, nrst, phyResetDone, identDone, openReq, stopArbReq, rxOpenFrame, rxOpenCrcErr;
  logic rxBreak, linkErr, stateExit;
  logic [63:0] localId, reqDestId, rxDestId, rxSrcId;
  logic [15:0] reqAwt, rxAwt;
  logic [3:0] reqRate, rxRate;
  logic [2:0] reqProto, supportedProtos, rxProto, rxRejectCode;
  logic [1:0] mode; // Remote answer kind
  wire txIdle, txOpenFrame, txAlignAllowed, cnfValid, cnfOpened, selValid, connHashValid;
  wire txOpenDone, rxAip, rxOpenAccept, rxOpenReject;
  wire [63:0] txDestId, selDestId;
  wire [15:0] txAwt, cnfAwt;
  wire [3:0] txRate, selRate, cnfReason;
  wire [2:0] txProto, cnfProto, selProto;
  wire [23:0] connHash;
  wire [7:0] state;
  int n_fail, check_count, cyc;
  lcf_link_connection_fsm #(.TMO_CYC(20)) uut (.*);
  lcf_remote_port rp (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task summarize;
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for a state
  task wst(input logic [7:0] s);
    for (int i = 0; i < 20 && state !== s; i++) step();
    if (state !== s) begin
      n_fail++;
      summarize();
    end
  endtask
  // Bounded wait for a confirmation or selection
  task wev;
    cyc = 0;
    do begin
      step();
      cyc++;
    end while (!(cnfValid === 1'b1 || cnfOpened === 1'b1 || selValid === 1'b1) && cyc < 200);
    if (cyc >= 200) begin
      n_fail++;
      summarize();
    end
  endtask
  task go_idle(input logic [1:0] m);
    @(posedge clk);
    nrst <= 1'b0;
    mode <= m;
    @(posedge clk);
    nrst <= 1'b1;
    wst(`LCF_ST_IDLE);
  endtask
  task arb(input logic [2:0] p, input logic [2:0] rc);
    @(posedge clk);
    {openReq, reqProto, rxRejectCode} <= {1'b1, p, rc};
    @(posedge clk);
    openReq <= 1'b0;
    #1;
    `CHK(state, `LCF_ST_ARB)
    `CHK({txOpenFrame, txDestId, txProto, txAwt, txRate}, {1'b1, reqDestId, p, reqAwt, reqRate})
  endtask
  task opn(input logic [15:0] a, input logic e);
    @(posedge clk);
    {rxOpenFrame, rxAwt, rxOpenCrcErr} <= {1'b1, a, e};
    @(posedge clk);
    rxOpenFrame <= 1'b0;
    #1;
  endtask
  task t_init;
    @(posedge clk);
    phyResetDone <= 1'b1;
    repeat (3) step();
    `CHK({state, txAlignAllowed}, {`LCF_ST_RESET, 1'b1})
    @(posedge clk);
    identDone <= 1'b1;
    wst(`LCF_ST_IDLE);
    `CHK(txIdle, 1'b1)
    opn(16'h0, 1'b1);
    `CHK(state, `LCF_ST_IDLE)
    @(posedge clk);
    supportedProtos <= 3'h1;
    opn(16'h0, 1'b0);
    `CHK(state, `LCF_ST_IDLE)
    @(posedge clk);
    supportedProtos <= 3'h7;
    opn(16'h0, 1'b0);
    `CHK({selValid, state, selProto, selRate, selDestId}, {1'b1, `LCF_ST_SEL, rxProto, rxRate, localId})
  endtask
  task t_open;
    logic [63:0] hx;
    hx = localId ^ reqDestId;
    for (int i = 0; i < 3; i++) begin
      go_idle(2'd0);
      arb(3'h1 << i, 3'h0);
      wev();
      `CHK({cnfOpened, cnfProto, state}, {1'b1, 3'h1 << i, `LCF_ST_OPEN})
      `CHK(connHashValid, i != 2)
      if (i != 2) `CHK(connHash, hx[23:0])
    end
  endtask
  task t_reject;
    for (int c = 0; c < 5; c++) begin
      go_idle(2'd1);
      arb(`LCF_PROTO_SSP, 3'(c));
      wev();
      `CHK({cnfValid, cnfReason, state}, {1'b1, 4'(c + 1), `LCF_ST_IDLE})
      if (c == 0) `CHK(cnfAwt, reqAwt)
    end
  endtask
  task t_timer;
    int t2;
    go_idle(2'd2);
    arb(`LCF_PROTO_SSP, 3'h0);
    wev();
    t2 = cyc;
    `CHK({cnfReason, state, t2 >= 20}, {4'h9, `LCF_ST_ABORTW, 1'b1})
    go_idle(2'd3);
    arb(`LCF_PROTO_SSP, 3'h0);
    wev();
    `CHK(cyc, t2 + 5)
  endtask
  task t_abort;
    for (int k = 0; k < 3; k++) begin
      go_idle(2'd2);
      arb(`LCF_PROTO_SSP, 3'h0);
      @(posedge clk);
      {stopArbReq, rxBreak, linkErr} <= 3'h4 >> k;
      @(posedge clk);
      {stopArbReq, rxBreak, linkErr, stateExit} <= {3'h0, k == 1};
      #1;
      if (k == 0) `CHK({cnfValid, cnfReason, state}, {1'b1, 4'h8, `LCF_ST_ABORTW})
      if (k == 1) `CHK({cnfValid, cnfReason, state}, {1'b1, 4'ha, `LCF_ST_ABORT})
      if (k == 2) `CHK({cnfValid, state}, {1'b0, `LCF_ST_ABORTW})
      @(posedge clk);
      stateExit <= 1'b0;
      #1;
      if (k == 1) `CHK(state, `LCF_ST_IDLE)
    end
  endtask
  task t_fair;
    go_idle(2'd2);
    arb(`LCF_PROTO_SSP, 3'h0);
    opn(16'h0010, 1'b0);
    `CHK(state, `LCF_ST_ARB)
    opn(16'h1000, 1'b0);
    `CHK({selValid, state, selDestId}, {1'b1, `LCF_ST_SEL, localId})
    go_idle(2'd3);
    arb(`LCF_PROTO_SSP, 3'h0);
    repeat (12) @(posedge clk);
    opn(16'h0010, 1'b0);
    `CHK({selValid, state}, {1'b1, `LCF_ST_SEL})
  endtask
  initial begin
    {nrst, phyResetDone, identDone, openReq, stopArbReq, rxOpenFrame, rxOpenCrcErr} = '0;
    {rxBreak, linkErr, stateExit, mode, rxAwt, rxRejectCode} = '0;
    {localId, reqDestId, rxSrcId} = {64'h1234, 64'h00a5, 64'h0055};
    {reqAwt, reqRate, rxRate, reqProto} = {16'h0100, 4'h8, 4'h8, `LCF_PROTO_SSP};
    {supportedProtos, rxProto, rxDestId} = {3'h7, `LCF_PROTO_SMP, 64'h1234};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_init();
    t_open();
    t_reject();
    t_timer();
    t_abort();
    t_fair();
    summarize();
  end
endmodule
`default_nettype wire
